//--- wsq_defines.svh
// Register offsets, field positions, reset values and timing constants of the sequencer
`ifndef WSQ_DEFINES_SVH
`define WSQ_DEFINES_SVH
`define WSQ_ADDR_W 8
`define WSQ_SLOT_FIRST_ADDR 8'h0F
`define WSQ_SLOT_LAST_ADDR 8'h16
`define WSQ_CTRL_ADDR 8'h0C
`define WSQ_GO_BIT 0
`define WSQ_DELAY_FLAG_BIT 7
`define WSQ_SLOT_FIRST_RESET 8'h01
`define WSQ_SLOT_OTHER_RESET 8'h00
`define WSQ_NUM_SLOTS 8
`define WSQ_CLK_HZ 10_000_000
`define WSQ_DELAY_STEP_MS 10
`define WSQ_DELAY_STEP_CYCLES ((`WSQ_CLK_HZ / 1000) * `WSQ_DELAY_STEP_MS)
`endif

//--- wsq_pkg.sv
// Types shared by the waveform sequencer modules
package wsq_pkg;
   typedef enum logic [1:0] {WSQ_IDLE, WSQ_FETCH, WSQ_PLAY, WSQ_WAIT} wsq_state_e;
   typedef logic [7:0] wsq_byte_t;
endpackage

//--- wsq_delay_timer.sv
// Idle timer counting whole steps of ten milliseconds
`timescale 1ns/1ps
`include "wsq_defines.svh"
module wsq_delay_timer
   import wsq_pkg::*;
#(
   parameter int STEP_CYCLES = `WSQ_DELAY_STEP_CYCLES
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic abort_i,
   input wire logic [6:0] steps_i,
   output logic done_o
);
   typedef struct packed
   {
      logic [31:0] tick;
      logic [6:0] steps;
      logic busy;
      logic done;
   } wsq_tmr_s;
   wsq_tmr_s r;
   wsq_tmr_s next_r;
   always_comb
   begin
      next_r = r;
      next_r.done = 1'b0;
      if (abort_i)
      begin
         next_r.busy = 1'b0;
      end
      else if (start_i)
      begin
         next_r.tick = 32'h0000_0000;
         next_r.steps = steps_i;
         next_r.busy = (steps_i != 7'h00);
         next_r.done = (steps_i == 7'h00);
      end
      else if (r.busy)
      begin
         if (r.tick == 32'(STEP_CYCLES - 1))
         begin
            next_r.tick = 32'h0000_0000;
            next_r.steps = r.steps - 7'h01;
            if (r.steps == 7'h01)
            begin
               next_r.busy = 1'b0;
               next_r.done = 1'b1;
            end
         end
         else
         begin
            next_r.tick = r.tick + 32'h0000_0001;
         end
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end
   assign done_o = r.done;
endmodule

//--- wsq_slot_bank.sv
// Bank of eight sequencer slot registers
`timescale 1ns/1ps
`include "wsq_defines.svh"
module wsq_slot_bank
   import wsq_pkg::*;
#(
   parameter int NUM_SLOTS = `WSQ_NUM_SLOTS
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic wr_i,
   input wire logic [2:0] wr_idx_i,
   input wire logic [7:0] wr_data_i,
   input wire logic [2:0] rd_idx_i,
   output wsq_byte_t rd_data_o
);
   typedef struct packed
   {
      logic [NUM_SLOTS-1:0][7:0] slot;
   } wsq_bank_s;
   wsq_bank_s r;
   wsq_bank_s next_r;
   always_comb
   begin
      next_r = r;
      if (wr_i)
      begin
         next_r.slot[wr_idx_i] = wr_data_i;
      end
   end
   genvar g;
   generate
      for (g = 0; g < NUM_SLOTS; g++)
      begin : g_slot
         always_ff @(posedge clk_i)
         begin
            if (!rst_n_i)
            begin
               r.slot[g] <= (g == 0) ? `WSQ_SLOT_FIRST_RESET : `WSQ_SLOT_OTHER_RESET;
            end
            else
            begin
               r.slot[g] <= next_r.slot[g];
            end
         end
      end
   endgenerate
   assign rd_data_o = r.slot[rd_idx_i];
endmodule

//--- wsq_sequencer.sv
// Waveform sequencer: slot registers, process-fire bit and playback walk
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "wsq_defines.svh"
// Overview of operation
// - Delay flag set: idle ten ms times value
// - Delay flag clear: value is waveform identifier
// - Identifier goes out on EFFECT_INDEX_O with EFFECT_START_O
// - Fire bit starts playback at first slot
// - Advance slots; stop at zero or eight
// - Zero identifier ends sequence, plays nothing
// - First slot resets to effect one
// - Fire bit holds; clear aborts; trigger sets
// - Second slot shares first slot layout
module wsq_sequencer
   import wsq_pkg::*;
#(
   parameter int STEP_CYCLES = `WSQ_DELAY_STEP_CYCLES
)
(
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic TRIG_I,
   input wire logic EFFECT_DONE_I,
   output logic [7:0] RDATA_O,
   output logic EFFECT_START_O,
   output logic [6:0] EFFECT_INDEX_O,
   output logic PLAYING_O,
   output logic IDLING_O
);
   typedef struct packed
   {
      wsq_state_e state;
      logic [2:0] idx;
      logic go;
      logic [7:0] rdata;
      logic start;
      logic [6:0] effect;
      logic playing;
      logic idling;
   } wsq_seq_s;
   wsq_seq_s r;
   wsq_seq_s next_r;
   wsq_byte_t slot_data;
   logic slot_wr;
   logic [2:0] wr_idx;
   logic [2:0] rd_idx;
   logic in_slots;
   logic rd_in_slots;
   logic tmr_start;
   logic tmr_abort;
   logic tmr_done;
   wsq_byte_t rd_slot;
   logic [7:0] wr_off;
   logic [7:0] rd_off;
   logic sw_clear;
   logic fire;

   assign in_slots = (ADDR_I >= `WSQ_SLOT_FIRST_ADDR) && (ADDR_I <= `WSQ_SLOT_LAST_ADDR);
   assign wr_off = ADDR_I - `WSQ_SLOT_FIRST_ADDR;
   assign rd_off = ADDR_I - `WSQ_SLOT_FIRST_ADDR;
   assign slot_wr = WR_I && in_slots;
   assign wr_idx = wr_off[2:0];
   assign rd_in_slots = in_slots;
   assign sw_clear = WR_I && (ADDR_I == `WSQ_CTRL_ADDR) && !WDATA_I[`WSQ_GO_BIT];
   assign fire = TRIG_I || (WR_I && (ADDR_I == `WSQ_CTRL_ADDR) && WDATA_I[`WSQ_GO_BIT]);
   // Bank has two read views: register read and playback fetch share one port
   assign rd_idx = (r.state == WSQ_IDLE && RD_I && rd_in_slots) ? rd_off[2:0] : r.idx;
   assign rd_slot = slot_data;

   wsq_slot_bank #(.NUM_SLOTS(`WSQ_NUM_SLOTS)) u_bank
   (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .wr_i(slot_wr),
      .wr_idx_i(wr_idx),
      .wr_data_i(WDATA_I),
      .rd_idx_i(rd_idx),
      .rd_data_o(slot_data)
   );

   wsq_delay_timer #(.STEP_CYCLES(STEP_CYCLES)) u_timer
   (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .start_i(tmr_start),
      .abort_i(tmr_abort),
      .steps_i(slot_data[6:0]),
      .done_o(tmr_done)
   );

   always_comb
   begin
      next_r = r;
      next_r.start = 1'b0;
      next_r.rdata = 8'h00;
      tmr_start = 1'b0;
      tmr_abort = 1'b0;
      if (RD_I)
      begin
         if (ADDR_I == `WSQ_CTRL_ADDR)
         begin
            next_r.rdata[`WSQ_GO_BIT] = r.go;
         end
         else if (in_slots)
         begin
            next_r.rdata = rd_slot;
         end
      end

      case (r.state)
         WSQ_IDLE:
         begin
            if (fire)
            begin
               next_r.go = 1'b1;
               next_r.idx = 3'h0;
               next_r.state = WSQ_FETCH;
            end
         end
         WSQ_FETCH:
         begin
            if (slot_data[`WSQ_DELAY_FLAG_BIT])
            begin
               tmr_start = 1'b1;
               next_r.idling = 1'b1;
               next_r.state = WSQ_WAIT;
            end
            else if (slot_data[6:0] == 7'h00)
            begin
               next_r.go = 1'b0;
               next_r.state = WSQ_IDLE;
            end
            else
            begin
               next_r.effect = slot_data[6:0];
               next_r.start = 1'b1;
               next_r.playing = 1'b1;
               next_r.state = WSQ_PLAY;
            end
         end
         WSQ_PLAY, WSQ_WAIT:
         begin
            if ((r.state == WSQ_PLAY && EFFECT_DONE_I) || (r.state == WSQ_WAIT && tmr_done))
            begin
               next_r.playing = 1'b0;
               next_r.idling = 1'b0;
               if (r.idx == 3'(`WSQ_NUM_SLOTS - 1))
               begin
                  next_r.go = 1'b0;
                  next_r.state = WSQ_IDLE;
               end
               else
               begin
                  next_r.idx = r.idx + 3'h1;
                  next_r.state = WSQ_FETCH;
               end
            end
         end
         default:
         begin
            next_r.state = WSQ_IDLE;
         end
      endcase

      if (sw_clear && r.state != WSQ_IDLE)
      begin
         tmr_abort = 1'b1;
         next_r.go = 1'b0;
         next_r.playing = 1'b0;
         next_r.idling = 1'b0;
         next_r.start = 1'b0;
         next_r.effect = r.effect;
         next_r.state = WSQ_IDLE;
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign RDATA_O = r.rdata;
   assign EFFECT_START_O = r.start;
   assign EFFECT_INDEX_O = r.effect;
   assign PLAYING_O = r.playing;
   assign IDLING_O = r.idling;

   a_abort_stops: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (sw_clear && r.state != WSQ_IDLE) |=> (r.state == WSQ_IDLE && !r.go))
      else $error("abort did not stop playback");

   a_fire_starts: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (r.state == WSQ_IDLE && fire) |=> (r.go && r.idx == 3'h0 && r.state == WSQ_FETCH))
      else $error("fire did not start at first slot");

   a_zero_ends: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (r.state == WSQ_FETCH && slot_data == 8'h00 && !sw_clear) |=> (!r.go && !r.start))
      else $error("zero slot did not end sequence");

   a_delay_idles: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (r.state == WSQ_FETCH && slot_data[`WSQ_DELAY_FLAG_BIT] && !sw_clear)
      |=> (r.idling && !r.start))
      else $error("delay slot did not idle");

   a_effect_index: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (r.state == WSQ_FETCH && !slot_data[`WSQ_DELAY_FLAG_BIT] && slot_data[6:0] != 7'h00
      && !sw_clear) |=> (r.start && r.effect == $past(slot_data[6:0])))
      else $error("effect index wrong");

   a_last_slot_done: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (r.state == WSQ_PLAY && EFFECT_DONE_I && r.idx == 3'(`WSQ_NUM_SLOTS - 1) && !sw_clear)
      |=> !r.go)
      else $error("fire bit held after eighth slot");

   a_slot_advance: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (r.state == WSQ_PLAY && EFFECT_DONE_I && r.idx != 3'(`WSQ_NUM_SLOTS - 1) && !sw_clear)
      |=> (r.idx == $past(r.idx) + 3'h1))
      else $error("slot did not advance");

   a_go_holds: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (r.state != WSQ_IDLE) |-> r.go)
      else $error("fire bit dropped during playback");

   a_wait_advance: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (r.state == WSQ_WAIT && tmr_done && r.idx != 3'(`WSQ_NUM_SLOTS - 1) && !sw_clear)
      |=> (r.state == WSQ_FETCH && r.idx == $past(r.idx) + 3'h1))
      else $error("delay slot did not advance");

   a_wait_last_done: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (r.state == WSQ_WAIT && tmr_done && r.idx == 3'(`WSQ_NUM_SLOTS - 1) && !sw_clear)
      |=> (r.state == WSQ_IDLE && !r.go))
      else $error("fire bit held after eighth delay slot");

   a_start_pulse: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      r.start
      |=> !r.start)
      else $error("effect start longer than one cycle");

   a_start_playing: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      r.start
      |-> (r.playing && r.state == WSQ_PLAY))
      else $error("effect start without playback");

   a_delay_quiet: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      r.idling
      |-> (!r.playing && !r.start))
      else $error("effect output during delay");

   a_idle_outputs: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (r.state == WSQ_IDLE)
      |-> (!r.go && !r.playing && !r.idling))
      else $error("activity left after playback end");

   a_play_holds: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (r.state == WSQ_PLAY && !EFFECT_DONE_I && !sw_clear)
      |=> (r.state == WSQ_PLAY && r.playing))
      else $error("effect left before done");

   a_wait_holds: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (r.state == WSQ_WAIT && !tmr_done && !sw_clear)
      |=> (r.state == WSQ_WAIT && r.idling))
      else $error("delay left before timer end");

   a_fetch_once: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (r.state == WSQ_FETCH)
      |=> (r.state != WSQ_FETCH))
      else $error("slot fetch stalled");

   a_effect_steady: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      $changed(r.effect)
      |-> r.start)
      else $error("effect index changed without start");

   a_ctrl_read: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (RD_I && ADDR_I == `WSQ_CTRL_ADDR)
      |=> (r.rdata[`WSQ_GO_BIT] == $past(r.go)))
      else $error("fire bit read back wrong");

   a_abort_quiet: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (sw_clear && r.state != WSQ_IDLE)
      |=> (!r.playing && !r.idling && !r.start))
      else $error("output active after abort");

   a_busy_ignores: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (r.state == WSQ_PLAY && fire && !EFFECT_DONE_I && !sw_clear)
      |=> (r.state == WSQ_PLAY && r.idx == $past(r.idx)))
      else $error("fire while busy restarted playback");

   a_first_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      $rose(r.go)
      |-> (r.idx == 3'h0 && r.state == WSQ_FETCH))
      else $error("playback did not begin at first slot");

   a_stop_no_play: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (r.state == WSQ_FETCH && slot_data == 8'h00 && !sw_clear)
      |=> (r.state == WSQ_IDLE && !r.playing && !r.idling))
      else $error("zero slot was played");
endmodule

//--- wsq_sequencer_tb_top.sv
// Self-checking testbench of the waveform sequencer
`timescale 1ns/1ps
`include "wsq_defines.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module wsq_sequencer_tb_top
   import wsq_pkg::*;
;
   localparam int STEP = 10;
   logic clk, rst_n, wr, rd, trig, fx_done, rd_prev;
   logic [7:0] addr, wdata, rdata, e_rd, e_fx, v;
   logic fx_start, playing, idling;
   logic [6:0] fx_index;
   logic [7:0] exp_rd[$];
   logic [7:0] exp_fx[$];
   logic [7:0] vals[8];
   logic [31:0] rnd;
   int err_count, checked, n;

   wsq_sequencer #(.STEP_CYCLES(STEP)) dut (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .TRIG_I(trig), .EFFECT_DONE_I(fx_done),
      .RDATA_O(rdata), .EFFECT_START_O(fx_start), .EFFECT_INDEX_O(fx_index),
      .PLAYING_O(playing), .IDLING_O(idling));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      exp_rd.push_back(e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask

   task automatic wait_play;
      n = 0;
      @(negedge clk);
      while (playing !== 1'b1 && n < 300)
      begin
         @(negedge clk);
         n++;
      end
      `CHK("playing", 1'b1, playing)
   endtask

   task automatic serve_fx;
      wait_play();
      @(posedge clk);
      fx_done <= 1'b1;
      @(posedge clk);
      fx_done <= 1'b0;
   endtask

   // Result watcher: oldest note against what the outputs show
   always @(negedge clk)
   begin
      if (rd_prev === 1'b1)
      begin
         e_rd = (exp_rd.size() > 0) ? exp_rd.pop_front() : 8'hff;
         `CHK("rdata", e_rd, rdata)
      end
      rd_prev = rd;
      if (fx_start === 1'b1)
      begin
         e_fx = (exp_fx.size() > 0) ? exp_fx.pop_front() : 8'hff;
         `CHK("fx_index", e_fx, {1'b0, fx_index})
      end
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      report_and_stop();
   end

   initial
   begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      trig = 1'b0;
      fx_done = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      rd_prev = 1'b0;
      rnd = 32'h0000_799a;
      err_count = 0;
      checked = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(`WSQ_SLOT_FIRST_ADDR, `WSQ_SLOT_FIRST_RESET);
      for (int i = 1; i < 8; i++) rd_reg(8'h0F + i[7:0], 8'h00);
      rd_reg(`WSQ_CTRL_ADDR, 8'h00);
      wr_reg(8'h20, 8'hAA);
      rd_reg(8'h20, 8'h00);
      $display("test reset_values done");
      for (int i = 0; i < 8; i++)
      begin
         rnd = lfsr(rnd);
         vals[i] = rnd[7:0];
         wr_reg(8'h0F + i[7:0], vals[i]);
      end
      for (int i = 0; i < 8; i++) rd_reg(8'h0F + i[7:0], vals[i]);
      $display("test slot_access done");
      rnd = lfsr(rnd);
      v = {1'b0, rnd[6:0]} | 8'h01;
      wr_reg(8'h0F, v);
      wr_reg(8'h10, 8'h83);
      wr_reg(8'h11, 8'h09);
      wr_reg(8'h12, 8'h00);
      exp_fx.push_back(v);
      exp_fx.push_back(8'h09);
      wr_reg(`WSQ_CTRL_ADDR, 8'h01);
      serve_fx();
      n = 0;
      while (idling !== 1'b1 && n < 20)
      begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (idling === 1'b1 && n < 1000)
      begin
         @(negedge clk);
         n++;
      end
      `CHK("idle_len", 1'b1, (n >= 3 * STEP && n <= 3 * STEP + 1))
      serve_fx();
      repeat (6) @(posedge clk);
      rd_reg(`WSQ_CTRL_ADDR, 8'h00);
      `CHK("fx_left", 0, exp_fx.size())
      $display("test delay_and_stop done");
      for (int i = 0; i < 8; i++)
      begin
         rnd = lfsr(rnd);
         v = {1'b0, rnd[6:0]} | 8'h01;
         wr_reg(8'h0F + i[7:0], v);
         exp_fx.push_back(v);
      end
      @(posedge clk);
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      repeat (8) serve_fx();
      repeat (6) @(posedge clk);
      rd_reg(`WSQ_CTRL_ADDR, 8'h00);
      `CHK("fx_left", 0, exp_fx.size())
      $display("test eight_slots done");
      wr_reg(8'h0F, 8'h04);
      exp_fx.push_back(8'h04);
      wr_reg(`WSQ_CTRL_ADDR, 8'h01);
      wait_play();
      rd_reg(`WSQ_CTRL_ADDR, 8'h01);
      wr_reg(`WSQ_CTRL_ADDR, 8'h00);
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK("abort", 1'b0, playing)
      @(posedge clk);
      fx_done <= 1'b1;
      @(posedge clk);
      fx_done <= 1'b0;
      repeat (20) @(posedge clk);
      @(negedge clk);
      `CHK("abort_quiet", 1'b0, playing)
      rd_reg(`WSQ_CTRL_ADDR, 8'h00);
      `CHK("fx_left", 0, exp_fx.size())
      $display("test abort done");
      report_and_stop();
   end
endmodule
